/* rtl/ptu_timer.sv */
// pwm timer unit 0 with interrupt sources behind a classic wishbone slave
// assumes pins arrive asynchronous to clk_i and one wishbone master on clk_i
// What this block does
// R1 - irq on output rise, fall and stop
// R2 - separate enables at control one bits 6..4
// R3 - fall irq: timer midpoint, pwm high end
// R4 - compare 0 or ffff: irq each period end
// R5 - global unit mask gates irq to core
// R6 - control one bit 7: timer or pwm
// R7 - control one bit 3: start level or edge
// R8 - control one bit 2: software run control
// R9 - control one bit 1: clear level or edge
// R10 - control one bit 0: active-low software clear
// R11 - control two bit 5: pulse or square
// R12 - divide by two to the exponent, max 16
// R13 - control three sync masks bits 7, 5
// R14 - control three bit 4: clock source
// R15 - control three bits 3..2: start source
// R16 - control three bits 1..0: clear source
// R17 - polarity bit 4: clear pin polarity
// R18 - polarity bit 3: start pin polarity
// R19 - live count readable at 015h, 016h
// R20 - status: overflow, pin, set state, running
// R21 - capture bytes hold count at stop
// R22 - compare high pending until low write
// R23 - reload resets ff, same byte ordering
// R24 - pwm high then low at compare
// R25 - compare equals reload high, zero low
// R26 - compare deferred to phase end, reload immediate
// R27 - level start counts; edge toggles run
// R28 - one-cycle irq, sticky readable flags
// R29 - clear zeroes counter and overflow together
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

`include "ptu_cfg.svh"

module ptu_timer (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   input  wire logic                  we_i,
   input  wire logic [11:0]           adr_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic [31:0]           dat_i,
   output logic      [31:0]           dat_o,
   output logic                       ack_o,
   input  wire ptu_pkg::ptu_pins_type pins_i,
   output logic                       wave_output_o,
   output logic                       wave_output_oe_o,
   output logic                       irq_o
);
   import ptu_pkg::*;

   logic [7:0]     start_clear_polarity;
   logic [7:0]     unit_control_one;
   logic [7:0]     unit_control_two;
   logic [7:0]     unit_control_three;
   logic [7:0]     compare_high_byte;
   logic [7:0]     reload_high_byte;
   logic [1:0]     irq_mask;
   logic [15:0]    compare_buffer;
   logic [15:0]    compare_active;
   logic [15:0]    reload_value;
   logic [15:0]    count;
   logic [15:0]    capture;
   logic [15:0]    presc_count;
   logic           overflow_flag;
   logic           wave_output;
   logic           run_state;
   logic [2:0]     event_flags;
   ptu_pins_type   pin_meta;
   ptu_pins_type   pin_sync;
   ptu_pins_type   pin_prev;
   logic           start_prev;
   ptu_space_type  space;
   logic [5:0]     idx;
   logic           bus_req;
   logic           wr_en;
   logic           rd_en;
   logic [7:0]     next_rdata;
   logic [4:0]     exponent;
   logic [15:0]    presc_mask;
   logic           src_tick;
   logic           presc_tick;
   logic           pwm_mode;
   logic           clear_pin_act;
   logic           clear_hit;
   logic           cleared;
   logic           start_pin_act;
   logic           start_sig;
   logic           next_run;
   logic           counting;
   logic           phase_end;
   logic [15:0]    next_count;
   logic           next_wave;
   logic           edge_period;
   ptu_events_type evt;
   logic [2:0]     evt_vec;
   logic [2:0]     evt_en;
   logic [2:0]     flag_clr;

   // wishbone decode, byte address bits 9:8 pick the space
   assign space   = ptu_space_type'(adr_i[9:8]);
   assign idx     = adr_i[7:2];
   assign bus_req = cyc_i & stb_i & ~ack_o;
   assign wr_en   = cyc_i & stb_i & we_i & ack_o & sel_i[0];
   assign rd_en   = cyc_i & stb_i & ~we_i & ack_o;

   always_comb begin
      next_rdata = 8'h00;
      if (adr_i[11:10] != 2'b00) begin
         next_rdata = 8'h00;
      end else if (space == PTU_CFG && idx == `PTU_IDX_POL) begin
         next_rdata = {3'h0, start_clear_polarity[4:3], 3'h0};
      end else if (space == PTU_CFG && idx == `PTU_IDX_CR1) begin
         next_rdata = unit_control_one;
      end else if (space == PTU_CFG && idx == `PTU_IDX_CR2) begin
         next_rdata = {2'h0, unit_control_two[5:0]};
      end else if (space == PTU_CFG && idx == `PTU_IDX_CR3) begin
         next_rdata = {unit_control_three[7], 1'b0, unit_control_three[5:0]};
      end else if (space == PTU_CFG && idx == `PTU_IDX_EVT) begin
         next_rdata = {5'h0, event_flags};
      end else if (space == PTU_CFG && idx == `PTU_IDX_IMASK) begin
         next_rdata = {6'h0, irq_mask};
      end else if (space == PTU_IN && idx == `PTU_IDX_CNT_H) begin
         next_rdata = count[15:8]; // R19
      end else if (space == PTU_IN && idx == `PTU_IDX_CNT_L) begin
         next_rdata = count[7:0]; // R19
      end else if (space == PTU_IN && idx == `PTU_IDX_STAT) begin
         next_rdata = {4'h0, overflow_flag, wave_output, ~cleared, run_state}; // R20
      end else if (space == PTU_IN && idx == `PTU_IDX_CAP_H) begin
         next_rdata = capture[15:8]; // R21
      end else if (space == PTU_IN && idx == `PTU_IDX_CAP_L) begin
         next_rdata = capture[7:0]; // R21
      end else begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= bus_req;
         if (bus_req) begin
            dat_o <= {24'h0, next_rdata};
         end
      end
   end

   // configuration space registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_clear_polarity <= `PTU_RST_BYTE;
         unit_control_one     <= `PTU_RST_BYTE;
         unit_control_two     <= `PTU_RST_BYTE;
         unit_control_three   <= `PTU_RST_BYTE;
         irq_mask             <= 2'h0;
      end else if (wr_en && adr_i[11:10] == 2'b00 && space == PTU_CFG) begin
         if (idx == `PTU_IDX_POL) begin
            start_clear_polarity <= dat_i[7:0]; // R17 R18
         end else if (idx == `PTU_IDX_CR1) begin
            unit_control_one <= dat_i[7:0]; // R2 R6 R7 R8 R9 R10
         end else if (idx == `PTU_IDX_CR2) begin
            unit_control_two <= dat_i[7:0]; // R11 R12
         end else if (idx == `PTU_IDX_CR3) begin
            unit_control_three <= dat_i[7:0]; // R13 R14 R15 R16
         end else if (idx == `PTU_IDX_IMASK) begin
            irq_mask <= dat_i[1:0];
         end
      end
   end

   // output space: high bytes wait, low byte write moves the pair
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_high_byte <= `PTU_RST_BYTE;
         compare_buffer    <= {2{`PTU_RST_BYTE}};
         reload_high_byte  <= `PTU_RST_RELOAD;
         reload_value      <= {2{`PTU_RST_RELOAD}};
      end else if (wr_en && adr_i[11:10] == 2'b00 && space == PTU_OUT) begin
         if (idx == `PTU_IDX_CMP_H) begin
            compare_high_byte <= dat_i[7:0]; // R22
         end else if (idx == `PTU_IDX_CMP_L) begin
            compare_buffer <= {compare_high_byte, dat_i[7:0]}; // R22
         end else if (idx == `PTU_IDX_REL_H) begin
            reload_high_byte <= dat_i[7:0]; // R23
         end else if (idx == `PTU_IDX_REL_L) begin
            reload_value <= {reload_high_byte, dat_i[7:0]}; // R23 R26
         end
      end
   end

   // pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= pins_i;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // prescaler, exponent clamped to the allowed maximum
   assign exponent   = (unit_control_two[`PTU_CR2_EXP_HI:0] > `PTU_EXP_MAX) ? `PTU_EXP_MAX
                       : unit_control_two[`PTU_CR2_EXP_HI:0]; // R12
   assign presc_mask = 16'((17'h1 << exponent) - 17'h1); // R12
   assign src_tick   = unit_control_three[`PTU_CR3_CLK_SRC] ?
                       (pin_sync.count_clock & ~pin_prev.count_clock) : 1'b1; // R14
   assign presc_tick = src_tick && ((presc_count & presc_mask) == presc_mask);

   always_ff @(posedge clk_i) begin
      if (rst_i || cleared) begin
         presc_count <= 16'h0;
      end else if (src_tick) begin
         presc_count <= presc_tick ? 16'h0 : 16'(presc_count + 16'h1);
      end
   end

   // clear and set
   assign pwm_mode      = unit_control_one[`PTU_CR1_MODE]; // R6
   assign clear_pin_act = unit_control_one[`PTU_CR1_CLEAR_EDGE] ?
                          (start_clear_polarity[`PTU_POL_CLEAR] ? (pin_prev.clear & ~pin_sync.clear)
                                                                : (~pin_prev.clear & pin_sync.clear))
                          : (pin_sync.clear == start_clear_polarity[`PTU_POL_CLEAR]); // R9 R17

   always_comb begin
      case (unit_control_three[`PTU_CR3_CLEAR_HI -: 2])
         `PTU_SRC_PIN:  clear_hit = clear_pin_act; // R16
         `PTU_SRC_BOTH: clear_hit = clear_pin_act | ~unit_control_one[`PTU_CR1_RELEASE]; // R16
         default:       clear_hit = ~unit_control_one[`PTU_CR1_RELEASE]; // R10 R16
      endcase
   end

   assign cleared = unit_control_three[`PTU_CR3_U0_SYNC] | clear_hit; // R13

   // start and stop
   assign start_pin_act = pin_sync.start ^ start_clear_polarity[`PTU_POL_START]; // R18

   always_comb begin
      case (unit_control_three[`PTU_CR3_START_HI -: 2])
         `PTU_SRC_PIN:  start_sig = start_pin_act; // R15
         `PTU_SRC_BOTH: start_sig = start_pin_act | unit_control_one[`PTU_CR1_RUN]; // R15
         default:       start_sig = unit_control_one[`PTU_CR1_RUN]; // R8 R15
      endcase
   end

   always_comb begin
      next_run = run_state;
      if (cleared) begin
         next_run = 1'b0;
      end else if (pwm_mode) begin
         next_run = 1'b1;
      end else if (unit_control_one[`PTU_CR1_START_EDGE]) begin
         next_run = (start_sig & ~start_prev) ? ~run_state : run_state; // R7 R27
      end else begin
         next_run = start_sig; // R7 R27
      end
   end

   assign evt.stop = run_state & ~next_run & ~pwm_mode & ~cleared; // R1

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_state  <= 1'b0;
         start_prev <= 1'b0;
         capture    <= 16'h0;
      end else begin
         run_state  <= next_run;
         start_prev <= start_sig;
         if (evt.stop) begin
            capture <= count; // R21
         end
      end
   end

   // counter
   // pwm wraps one tick before reload, so a period spans reload ticks
   assign counting   = run_state & ~cleared;
   assign next_count = 16'(count + 16'h1);
   assign phase_end  = pwm_mode ? (next_count >= reload_value)
                       : (count >= compare_active || count >= reload_value); // R24

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count          <= 16'h0;
         overflow_flag  <= 1'b0;
         compare_active <= {2{`PTU_RST_BYTE}};
      end else if (cleared) begin
         count          <= 16'h0; // R29
         overflow_flag  <= 1'b0; // R29
         compare_active <= compare_buffer;
      end else if (!counting) begin
         compare_active <= compare_buffer;
      end else if (presc_tick) begin
         if (phase_end) begin
            count          <= 16'h0;
            overflow_flag  <= 1'b1;
            compare_active <= compare_buffer; // R26
         end else begin
            count <= next_count;
         end
      end
   end

   // waveform
   always_comb begin
      next_wave = 1'b0;
      if (cleared) begin
         next_wave = 1'b0;
      end else if (pwm_mode) begin
         if (compare_active == 16'h0) begin
            next_wave = 1'b0; // R25
         end else if (compare_active >= reload_value) begin
            next_wave = 1'b1; // R25
         end else begin
            next_wave = count < compare_active; // R24
         end
      end else if (unit_control_two[`PTU_CR2_WAVE]) begin
         next_wave = count < 16'((17'(compare_active) + 17'h1) >> 1); // R3 R11
      end else begin
         next_wave = overflow_flag && count == 16'h0 && counting; // R11
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wave_output <= 1'b0;
      end else begin
         wave_output <= next_wave;
      end
   end

   assign wave_output_o    = wave_output;
   assign wave_output_oe_o = ~cleared;

   // interrupt events
   assign edge_period = pwm_mode && (compare_active == 16'h0 || compare_active == `PTU_CNT_FULL);
   assign evt.rise    = edge_period ? (counting & presc_tick & phase_end)
                        : (next_wave & ~wave_output); // R1 R4
   assign evt.fall    = edge_period ? 1'b0 : (~next_wave & wave_output & ~cleared); // R1 R3 R4
   assign evt_vec     = evt;
   assign evt_en      = {unit_control_one[`PTU_CR1_STOP_IE], unit_control_one[`PTU_CR1_FALL_IE] |
                         (edge_period & unit_control_one[`PTU_CR1_FALL_IE]),
                         unit_control_one[`PTU_CR1_RISE_IE] |
                         (edge_period & unit_control_one[`PTU_CR1_FALL_IE])}; // R2 R4

   always_comb begin
      flag_clr = 3'h0;
      if (rd_en && adr_i[11:10] == 2'b00 && space == PTU_IN && idx == `PTU_IDX_STAT) begin
         flag_clr = 3'h7;
      end else if (wr_en && adr_i[11:10] == 2'b00 && space == PTU_CFG && idx == `PTU_IDX_EVT) begin
         flag_clr = dat_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_flags <= 3'h0;
         irq_o       <= 1'b0;
      end else begin
         event_flags <= (event_flags & ~flag_clr) | (evt_vec & evt_en); // R28
         irq_o       <= |(evt_vec & evt_en) & irq_mask[`PTU_IMASK_U0]; // R5 R28
      end
   end
endmodule

/* pkg/ptu_cfg.svh */
// offsets, field positions, reset values and limits of the pwm timer unit
// assumes inclusion by bare name from the package and the design file
`ifndef PTU_CFG_SVH
`define PTU_CFG_SVH

// register spaces, selected by byte address bits 9:8
`define PTU_SPACE_CFG      2'h0
`define PTU_SPACE_IN       2'h1
`define PTU_SPACE_OUT      2'h2
// register indices inside a space, byte address is four times (space * 64 + index)
`define PTU_IDX_POL        6'h01
`define PTU_IDX_CR1        6'h09
`define PTU_IDX_CR2        6'h0a
`define PTU_IDX_CR3        6'h0b
`define PTU_IDX_EVT        6'h3e
`define PTU_IDX_IMASK      6'h3f
`define PTU_IDX_CNT_H      6'h15
`define PTU_IDX_CNT_L      6'h16
`define PTU_IDX_STAT       6'h17
`define PTU_IDX_CAP_H      6'h18
`define PTU_IDX_CAP_L      6'h19
`define PTU_IDX_CMP_H      6'h07
`define PTU_IDX_CMP_L      6'h08
`define PTU_IDX_REL_H      6'h09
`define PTU_IDX_REL_L      6'h0a
// control register one fields
`define PTU_CR1_MODE       7
`define PTU_CR1_STOP_IE    6
`define PTU_CR1_FALL_IE    5
`define PTU_CR1_RISE_IE    4
`define PTU_CR1_START_EDGE 3
`define PTU_CR1_RUN        2
`define PTU_CR1_CLEAR_EDGE 1
`define PTU_CR1_RELEASE    0
// control register two fields
`define PTU_CR2_WAVE       5
`define PTU_CR2_EXP_HI     4
`define PTU_EXP_MAX        5'h10
// control register three fields
`define PTU_CR3_U0_SYNC    7
`define PTU_CR3_U1_SYNC    5
`define PTU_CR3_CLK_SRC    4
`define PTU_CR3_START_HI   3
`define PTU_CR3_CLEAR_HI   1
// polarity register fields
`define PTU_POL_CLEAR      4
`define PTU_POL_START      3
// global mask register fields and event register fields
`define PTU_IMASK_U0       0
`define PTU_IMASK_U1       1
`define PTU_EVT_STOP       2
`define PTU_EVT_FALL       1
`define PTU_EVT_RISE       0
// source select codes
`define PTU_SRC_SOFT       2'h0
`define PTU_SRC_PIN        2'h1
`define PTU_SRC_BOTH       2'h2
// reset values and the full counter value
`define PTU_RST_BYTE       8'h00
`define PTU_RST_RELOAD     8'hff
`define PTU_CNT_FULL       16'hffff

`endif

/* pkg/ptu_pkg.sv */
// types shared by the pwm timer unit
// assumes the constants header is on the include path
package ptu_pkg;
   `include "ptu_cfg.svh"

   typedef enum logic [1:0] {
      PTU_CFG = 2'b00,
      PTU_IN  = 2'b01,
      PTU_OUT = 2'b10,
      PTU_NONE = 2'b11
   } ptu_space_type;

   typedef struct packed {
      logic count_clock;
      logic start;
      logic clear;
   } ptu_pins_type;

   typedef struct packed {
      logic stop;
      logic fall;
      logic rise;
   } ptu_events_type;
endpackage

/* testbench/ptu_timer_chk.sv */
// port assertions for the pwm timer unit
// assumes a bind onto ptu_timer; bus writes land at the ack edge
`timescale 1ns/1ps
module ptu_timer_chk (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  cyc_i,
   input wire logic                  stb_i,
   input wire logic                  we_i,
   input wire logic [11:0]           adr_i,
   input wire logic [3:0]            sel_i,
   input wire logic [31:0]           dat_i,
   input wire logic [31:0]           dat_o,
   input wire logic                  ack_o,
   input wire ptu_pkg::ptu_pins_type pins_i,
   input wire logic                  wave_output_o,
   input wire logic                  wave_output_oe_o,
   input wire logic                  irq_o
);
   import ptu_pkg::*;
   logic [7:0] cr1;
   logic [7:0] cr3;
   logic       msk;
   wire        wr_done = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   wire        ien     = |cr1[6:4];
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // shadow of the control bits that gate the outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cr1 <= 8'h00;
         cr3 <= 8'h00;
         msk <= 1'b0;
      end else if (wr_done && adr_i == 12'h024) begin
         cr1 <= dat_i[7:0];
      end else if (wr_done && adr_i == 12'h02c) begin
         cr3 <= dat_i[7:0];
      end else if (wr_done && adr_i == 12'h0fc) begin
         msk <= dat_i[0];
      end
   end
   sequence taken_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence read_s;
      taken_s ##0 !we_i;
   endsequence
   ack_next_a: assert property (taken_s |=> ack_o) else $error("no ack one cycle after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   reset_quiet_a: assert property ($fell(rst_i) |-> !wave_output_oe_o && !wave_output_o && !irq_o)
      else $error("outputs active after reset");
   upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read data upper bits set");
   wo_read_zero_a: assert property (read_s ##0 (adr_i[9] || adr_i[11:10] != 2'h0) |=> dat_o == 32'h0)
      else $error("write-only or unmapped read not zero");
   status_pin_a: assert property (read_s ##0 adr_i == 12'h15c |=>
      dat_o[2:1] == {$past(wave_output_o), $past(wave_output_oe_o)}) else $error("status pin or set bit wrong");
   irq_gate_a: assert property (irq_o |-> msk || $past(msk) || $past(msk, 2))
      else $error("irq while unit masked");
   irq_src_a: assert property (irq_o |-> ien || $past(ien) || $past(ien, 2))
      else $error("irq with all sources disabled");
   clear_oe_a: assert property (cr3[1:0] == 2'h0 && !cr1[1] && $stable(cr1) && $stable(cr3) |->
      wave_output_oe_o == (cr1[0] && !cr3[7])) else $error("output enable disagrees with clear state");
endmodule
bind ptu_timer ptu_timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pins_i(pins_i),
   .wave_output_o(wave_output_o), .wave_output_oe_o(wave_output_oe_o), .irq_o(irq_o));

/* testbench/ptu_pins_model.sv */
// pin-side model of the pwm timer unit: start, clear and count clock
// assumes the bench sets pin levels; count clock stands low when disabled
`timescale 1ns/1ps
module ptu_pins_model (
   input  wire logic             clk_i,
   input  wire logic             start_i,
   input  wire logic             clear_i,
   input  wire logic             tick_en_i,
   output ptu_pkg::ptu_pins_type pins_o
);
   import ptu_pkg::*;
   logic [1:0] div = 2'h0;
   logic       ck  = 1'b0;
   // count clock at an eighth of the master clock
   always_ff @(posedge clk_i) begin
      div <= tick_en_i ? div + 2'h1 : 2'h0;
      ck  <= tick_en_i && (ck ^ (div == 2'h3));
   end
   assign pins_o = {ck, start_i, clear_i};
endmodule

/* testbench/ptu_timer_tb.sv */
// self-checking bench for the pwm timer unit
// assumes ptu_timer, its checker and the pin model are compiled before it
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module ptu_timer_tb;
   import ptu_pkg::*;
   logic         clk_i;
   logic         rst_i   = 1'b1;
   logic         cyc_i   = 1'b0;
   logic         stb_i   = 1'b0;
   logic         we_i    = 1'b0;
   logic [11:0]  adr_i   = 12'h000;
   logic [3:0]   sel_i   = 4'h0;
   logic [31:0]  dat_i   = 32'h0;
   logic [31:0]  dat_o;
   logic         ack_o;
   ptu_pins_type pins;
   logic         wave;
   logic         oe;
   logic         irq;
   logic         start   = 1'b0;
   logic         clear   = 1'b1;
   logic         tick_en = 1'b0;
   logic [15:0]  notes[$];
   logic [15:0]  note;
   logic [7:0]   last;
   logic [7:0]   d;
   int           mismatches = 0;
   int           cmp_count  = 0;
   int           hi, per, ic, i;
   logic [7:0]   rv [13] = '{8'h01, 8'h09, 8'h0a, 8'h0b, 8'h3e, 8'h3f, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h87,
                             8'hc0};
   ptu_pins_model u_pins (.clk_i(clk_i), .start_i(start), .clear_i(clear), .tick_en_i(tick_en), .pins_o(pins));
   ptu_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pins_i(pins), .wave_output_o(wave),
      .wave_output_oe_o(oe), .irq_o(irq));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic bus(input logic w, input logic [1:0] sp, input logic [5:0] ix, input logic [7:0] v);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {2'h0, sp, ix, 2'h0};
      sel_i <= 4'h1;
      dat_i <= {24'h0, v};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask
   task automatic wr(input logic [1:0] sp, input logic [5:0] ix, input logic [7:0] v);
      bus(1'b1, sp, ix, v);
   endtask
   task automatic rd(input logic [1:0] sp, input logic [5:0] ix, input logic [7:0] e, input logic [7:0] m);
      notes.push_back({e & m, m});
      bus(1'b0, sp, ix, 8'h00);
   endtask
   // one full period: cycles high and total length
   task automatic shape(output int h, output int p);
      int k;
      k = 0;
      h = 0;
      p = 0;
      while (wave !== 1'b0 && k < 2000) begin @(posedge clk_i); k++; end
      while (wave !== 1'b1 && k < 2000) begin @(posedge clk_i); k++; end
      while (wave === 1'b1 && p < 2000) begin @(posedge clk_i); h++; p++; end
      while (wave === 1'b0 && p < 2000) begin @(posedge clk_i); p++; end
   endtask
   task automatic watch(input int n, output int h, output int c);
      h = 0;
      c = 0;
      repeat (n) begin
         @(posedge clk_i);
         h += (wave === 1'b1);
         c += (irq === 1'b1);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // read results against the oldest note
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0) begin
         last = dat_o[7:0];
         if (notes.size() == 0) begin
            `CHECK("unexpected read", 1'b0, 1'b1)
         end else begin
            note = notes.pop_front();
            `CHECK($sformatf("read %h", adr_i), note[15:8], dat_o[7:0] & note[7:0])
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
   initial begin
      void'($urandom(32'h6b7f));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 13; i++) rd(rv[i][7:6], rv[i][5:0], 8'h00, 8'hff);
      d = 8'($urandom_range(0, 16)) | (8'($urandom) & 8'h20);
      wr(0, 6'h0a, d);
      rd(0, 6'h0a, d, 8'h3f);
      d = 8'($urandom) & 8'hfe;
      wr(0, 6'h09, d);
      rd(0, 6'h09, d, 8'hff);
      d = 8'($urandom);
      wr(0, 6'h0b, d);
      rd(0, 6'h0b, d, 8'hbf);
      d = 8'($urandom);
      wr(0, 6'h01, d);
      rd(0, 6'h01, d, 8'h18);
      wr(1, 6'h15, 8'h5a);
      rd(1, 6'h15, 8'h00, 8'hff);
      for (i = 0; i < 4; i++) wr(0, rv[i][5:0], 8'h00);
      wr(2, 6'h09, 8'h00);
      wr(2, 6'h0a, 8'h09);
      wr(2, 6'h07, 8'h00);
      wr(2, 6'h08, 8'h04);
      wr(0, 6'h3f, 8'h01);
      wr(0, 6'h09, 8'hb1);
      for (i = 2; i >= 0; i--) begin
         wr(0, 6'h0a, 8'(i));
         shape(hi, per);
         `CHECK("pwm high", 4 << i, hi)
         `CHECK("pwm period", 9 << i, per)
      end
      watch(9, hi, ic);
      `CHECK("edge irqs", 2, ic)
      rd(0, 6'h3e, 8'h03, 8'h03);
      rd(1, 6'h17, 8'h0b, 8'h0b);
      wr(2, 6'h08, 8'h07);
      shape(hi, per);
      `CHECK("new compare", 7, hi)
      wr(0, 6'h3f, 8'h00);
      watch(27, hi, ic);
      `CHECK("masked irqs", 0, ic)
      wr(0, 6'h3f, 8'h01);
      wr(2, 6'h08, 8'h09);
      repeat (20) @(posedge clk_i);
      watch(27, hi, ic);
      `CHECK("full duty", 27, hi)
      wr(2, 6'h08, 8'h00);
      repeat (20) @(posedge clk_i);
      watch(27, hi, ic);
      `CHECK("zero duty", 0, hi)
      `CHECK("zero irqs", 3, ic)
      wr(2, 6'h07, 8'hff);
      wr(2, 6'h08, 8'hff);
      repeat (20) @(posedge clk_i);
      watch(27, hi, ic);
      `CHECK("top irqs", 3, ic)
      wr(2, 6'h07, 8'h00);
      wr(2, 6'h08, 8'h04);
      tick_en <= 1'b1;
      wr(0, 6'h0b, 8'h10);
      shape(hi, per);
      `CHECK("ext high", 32, hi)
      `CHECK("ext period", 72, per)
      wr(0, 6'h0b, 8'h00);
      tick_en <= 1'b0;
      wr(0, 6'h09, 8'hb0);
      @(posedge clk_i);
      `CHECK("oe cleared", 1'b0, oe)
      rd(1, 6'h15, 8'h00, 8'hff);
      rd(1, 6'h16, 8'h00, 8'hff);
      rd(1, 6'h17, 8'h00, 8'h0b);
      wr(2, 6'h09, 8'hff);
      wr(2, 6'h0a, 8'hff);
      wr(2, 6'h08, 8'hff);
      wr(0, 6'h0b, 8'h04);
      wr(0, 6'h09, 8'h41);
      start <= 1'b1;
      repeat (30) @(posedge clk_i);
      rd(1, 6'h17, 8'h01, 8'h01);
      start <= 1'b0;
      watch(12, hi, ic);
      `CHECK("stop irq", 1, ic)
      rd(1, 6'h18, 8'h00, 8'hff);
      rd(1, 6'h19, 8'h00, 8'h00);
      @(posedge clk_i);
      `CHECK("capture low", 1'b1, last >= 8'd28 && last <= 8'd38)
      rd(1, 6'h17, 8'h02, 8'h03);
      wr(0, 6'h0b, 8'h01);
      clear <= 1'b0;
      repeat (6) @(posedge clk_i);
      rd(1, 6'h16, 8'h00, 8'hff);
      rd(1, 6'h17, 8'h00, 8'h0a);
      clear <= 1'b1;
      wr(0, 6'h01, 8'h10);
      repeat (6) @(posedge clk_i);
      rd(1, 6'h17, 8'h00, 8'h02);
      wr(0, 6'h01, 8'h00);
      repeat (6) @(posedge clk_i);
      rd(1, 6'h17, 8'h02, 8'h02);
      repeat (3) @(posedge clk_i);
      conclude();
   end
endmodule
